// ### design/pps_pkg.sv
/*
 * Package for the port statistics select register bank: register offset,
 * field positions, reset value, event type codes and the event carrier.
 * Assumes a 32-bit Wishbone data bus with byte addresses.
 */
package pps_pkg;

   localparam int          DATA_W        = 32;
   localparam int          SEL_W         = DATA_W / 8;
   localparam logic [7:0]  SEL_OFFSET    = 8'h00;
   localparam logic [31:0] SEL_RESET     = 32'h0000_0000;
   localparam logic [31:0] SEL_WMASK     = 32'hE08FE08F;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   // Field positions inside the select register
   localparam int C0_PRI3_BIT  = 0;
   localparam int C0_PRI2_BIT  = 1;
   localparam int C0_PRI1_BIT  = 2;
   localparam int C0_PRI0_BIT  = 3;
   localparam int C0_DIR_BIT   = 7;
   localparam int C0_TYPE_LSB  = 13;
   localparam int C1_PRI3_BIT  = 16;
   localparam int C1_PRI2_BIT  = 17;
   localparam int C1_PRI1_BIT  = 18;
   localparam int C1_PRI0_BIT  = 19;
   localparam int C1_DIR_BIT   = 23;
   localparam int C1_TYPE_LSB  = 29;
   localparam int TYPE_W       = 3;

   localparam logic DIR_RX = 1'b0;
   localparam logic DIR_TX = 1'b1;

   typedef enum logic [2:0] {
      PPS_EV_UC_REQ    = 3'h0,
      PPS_EV_UC_ALL    = 3'h1,
      PPS_EV_CS_RETRY  = 3'h2,
      PPS_EV_CS_OTHER  = 3'h3,
      PPS_EV_UC_WORDS  = 3'h4,
      PPS_EV_MC_PKT    = 3'h5,
      PPS_EV_MC_CS     = 3'h6,
      PPS_EV_MC_WORDS  = 3'h7
   } pps_ev_type_t;

   typedef enum logic [1:0] {
      PPS_PKT_REQUEST,
      PPS_PKT_RESPONSE,
      PPS_PKT_MAINT
   } pps_pkt_kind_t;

   // Traffic observed in one direction during one cycle
   typedef struct packed {
      logic          pkt_valid;
      logic          word_valid;
      logic [1:0]    prio;
      logic          mcast;
      pps_pkt_kind_t kind;
      logic          hop_zero;
      logic          retried;
      logic          cs_valid;
      logic          cs_retry;
      logic          cs_mcast;
   } pps_event_t;

   // Decoded setup of one statistics counter
   typedef struct packed {
      logic [3:0]   pri_en;
      logic         direction;
      pps_ev_type_t ev_type;
   } pps_ctr_cfg_t;

endpackage : pps_pkg

// ### design/pps_select.sv
/*
 * Select register for statistics counters 0 and 1 of one switch port,
 * with a classic Wishbone slave and the event qualification that turns
 * observed traffic into one-cycle count strobes for both counters.
 * Assumes the counters live outside and add one per strobe, and that the
 * event inputs come from logic on clk_i.
 */
// Operation
// - Bit 0 set lets counter 0 count priority 3 packets.
// - Bits 1, 2, 3 enable priorities 2, 1, 0 for counter 0.
// - Counter 0 counts nothing when all its priority bits are zero.
// - All four priority bits set count packets of every priority.
// - Bits 16, 17, 18 enable priorities 3, 2, 1 for counter 1.
// - Bit 19 set lets counter 1 count priority 0 packets.
// - Counter 1 counts nothing when all its priority bits are zero.
// - Bit 7 picks receive (0) or transmit (1) traffic for counter 0.
// - Bit 23 picks receive (0) or transmit (1) traffic for counter 1.
// - Bits 13 to 15 pick counter 0 event type; retried packets never count.
// - Type 000 counts unicast requests only, no responses or maintenance.
// - Type 001 counts all unicast packets, maintenance too whatever hop_zero is.
// - Type 010 counts retry control symbols only.
// - Type 011 counts control symbols other than retry.
// - Type 100 counts each 32-bit word of accepted unicast packets.
// - Type 101 counts multicast packets only.
// - Type 110 counts multicast control symbols.
// - Type 111 counts each 32-bit word of multicast packets.
`timescale 1ns/1ps

module pps_select
   import pps_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   // Wishbone slave
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [ADDR_W-1:0] adr_i,
   input  wire logic [SEL_W-1:0]  sel_i,
   input  wire logic [DATA_W-1:0] dat_i,
   output logic      [DATA_W-1:0] dat_o,
   output logic                   ack_o,
   // Observed traffic
   input  wire pps_event_t        ev_rx_i,
   input  wire pps_event_t        ev_tx_i,
   // Counter setup and count strobes
   output pps_ctr_cfg_t           ctr0_cfg_o,
   output pps_ctr_cfg_t           ctr1_cfg_o,
   output logic                   ctr0_inc_o,
   output logic                   ctr1_inc_o
);

   logic [DATA_W-1:0] sel_reg_q;
   logic              bus_req;
   logic              hit;
   logic [DATA_W-1:0] byte_mask;
   logic              ctr0_hit_d;
   logic              ctr1_hit_d;
   pps_ctr_cfg_t      ctr0_cfg_d;
   pps_ctr_cfg_t      ctr1_cfg_d;

   // Expand byte lanes into a bit mask
   function automatic logic [DATA_W-1:0] lane_mask(
      input logic [SEL_W-1:0] sel
   );
      logic [DATA_W-1:0] m;
      m = '0;
      for (int i = 0; i < SEL_W; i++) begin
         m[i*8 +: 8] = {8{sel[i]}};
      end
      return m;
   endfunction : lane_mask

   // Priority bit i of the field enables packet priority i
   function automatic logic prio_ok(
      input logic [3:0] pri_en,
      input logic [1:0] prio
   );
      return pri_en[prio];
   endfunction : prio_ok

   // Decide whether one direction's traffic counts under a setup
   function automatic logic qualify(
      input pps_ctr_cfg_t cfg,
      input pps_event_t   ev
   );
      logic hit_v;
      logic pkt_ok;
      logic word_ok;
      hit_v   = 1'b0;
      pkt_ok  = ev.pkt_valid && !ev.retried;
      word_ok = ev.word_valid && !ev.retried;
      case (cfg.ev_type)
         PPS_EV_UC_REQ: begin
            hit_v = pkt_ok && !ev.mcast
                    && ev.kind == PPS_PKT_REQUEST
                    && prio_ok(cfg.pri_en, ev.prio);
         end
         PPS_EV_UC_ALL: begin
            hit_v = pkt_ok && !ev.mcast
                    && prio_ok(cfg.pri_en, ev.prio);
         end
         PPS_EV_CS_RETRY: begin
            hit_v = ev.cs_valid && ev.cs_retry && !ev.cs_mcast;
         end
         PPS_EV_CS_OTHER: begin
            hit_v = ev.cs_valid && !ev.cs_retry && !ev.cs_mcast;
         end
         PPS_EV_UC_WORDS: begin
            hit_v = word_ok && !ev.mcast
                    && prio_ok(cfg.pri_en, ev.prio);
         end
         PPS_EV_MC_PKT: begin
            hit_v = pkt_ok && ev.mcast
                    && prio_ok(cfg.pri_en, ev.prio);
         end
         PPS_EV_MC_CS: begin
            hit_v = ev.cs_valid && ev.cs_mcast;
         end
         PPS_EV_MC_WORDS: begin
            hit_v = word_ok && ev.mcast
                    && prio_ok(cfg.pri_en, ev.prio);
         end
         default: begin
            hit_v = 1'b0;
         end
      endcase
      // An all-zero priority field turns the counter off
      if (cfg.pri_en == 4'h0) begin
         hit_v = 1'b0;
      end
      return hit_v;
   endfunction : qualify

   assign bus_req   = cyc_i && stb_i && !ack_o;
   assign byte_mask = lane_mask(sel_i);

   // Address decode
   always_comb begin
      if (adr_i[ADDR_W-1:2] == SEL_OFFSET[ADDR_W-1:2]) begin
         hit = 1'b1;
      end else begin
         hit = 1'b0;
      end
   end

   // Field decode of the stored register
   always_comb begin
      ctr0_cfg_d.pri_en[3] = sel_reg_q[C0_PRI3_BIT];
      ctr0_cfg_d.pri_en[2] = sel_reg_q[C0_PRI2_BIT];
      ctr0_cfg_d.pri_en[1] = sel_reg_q[C0_PRI1_BIT];
      ctr0_cfg_d.pri_en[0] = sel_reg_q[C0_PRI0_BIT];
      ctr0_cfg_d.direction = sel_reg_q[C0_DIR_BIT];
      ctr0_cfg_d.ev_type   = pps_ev_type_t'(
         sel_reg_q[C0_TYPE_LSB +: TYPE_W]);
      ctr1_cfg_d.pri_en[3] = sel_reg_q[C1_PRI3_BIT];
      ctr1_cfg_d.pri_en[2] = sel_reg_q[C1_PRI2_BIT];
      ctr1_cfg_d.pri_en[1] = sel_reg_q[C1_PRI1_BIT];
      ctr1_cfg_d.pri_en[0] = sel_reg_q[C1_PRI0_BIT];
      ctr1_cfg_d.direction = sel_reg_q[C1_DIR_BIT];
      ctr1_cfg_d.ev_type   = pps_ev_type_t'(
         sel_reg_q[C1_TYPE_LSB +: TYPE_W]);
   end

   // Event qualification for both counters
   always_comb begin
      if (ctr0_cfg_d.direction == DIR_TX) begin
         ctr0_hit_d = qualify(ctr0_cfg_d, ev_tx_i);
      end else begin
         ctr0_hit_d = qualify(ctr0_cfg_d, ev_rx_i);
      end
      if (ctr1_cfg_d.direction == DIR_TX) begin
         ctr1_hit_d = qualify(ctr1_cfg_d, ev_tx_i);
      end else begin
         ctr1_hit_d = qualify(ctr1_cfg_d, ev_rx_i);
      end
   end

   // Register write; reserved positions stay zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_reg_q <= SEL_RESET;
      end else if (ce_i) begin
         if (bus_req && we_i && hit) begin
            sel_reg_q <= (sel_reg_q & ~(byte_mask & SEL_WMASK))
                         | (dat_i & byte_mask & SEL_WMASK);
         end
      end
   end

   // Wishbone acknowledge, one cycle after the request appears
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else if (ce_i) begin
         ack_o <= bus_req;
      end
   end

   // Read data; unmapped addresses read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= UNMAPPED_DATA;
      end else if (ce_i) begin
         if (bus_req && !we_i && hit) begin
            dat_o <= sel_reg_q & SEL_WMASK;
         end else if (bus_req) begin
            dat_o <= UNMAPPED_DATA;
         end
      end
   end

   // Setup outputs mirror the register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctr0_cfg_o <= '0;
         ctr1_cfg_o <= '0;
      end else if (ce_i) begin
         ctr0_cfg_o <= ctr0_cfg_d;
         ctr1_cfg_o <= ctr1_cfg_d;
      end
   end

   // Count strobes, one cycle after the qualifying event
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctr0_inc_o <= 1'b0;
         ctr1_inc_o <= 1'b0;
      end else if (ce_i) begin
         ctr0_inc_o <= ctr0_hit_d;
         ctr1_inc_o <= ctr1_hit_d;
      end
   end

endmodule : pps_select

// ### test/pps_select_asserts.sv
/* Checker for the statistics select register bank.
   Assumes ce_i stays high around register writes. */
`timescale 1ns/1ps
module pps_select_asserts
   import pps_pkg::*;
#(parameter int ADDR_W = 8) (
   input wire logic              clk_i,
   input wire logic              rst_i,
   input wire logic              ce_i,
   input wire logic              cyc_i,
   input wire logic              stb_i,
   input wire logic              we_i,
   input wire logic [ADDR_W-1:0] adr_i,
   input wire logic [SEL_W-1:0]  sel_i,
   input wire logic [DATA_W-1:0] dat_i,
   input wire logic [DATA_W-1:0] dat_o,
   input wire logic              ack_o,
   input wire pps_event_t        ev_rx_i,
   input wire pps_event_t        ev_tx_i,
   input wire pps_ctr_cfg_t      ctr0_cfg_o,
   input wire pps_ctr_cfg_t      ctr1_cfg_o,
   input wire logic              ctr0_inc_o,
   input wire logic              ctr1_inc_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   function automatic logic live(pps_event_t e);
      return ((e.pkt_valid || e.word_valid) && !e.retried) || e.cs_valid;
   endfunction : live
   function automatic logic [7:0] cf(logic [31:0] d, logic hi);
      logic [15:0] h;
      h = hi ? d[31:16] : d[15:0];
      return {h[0], h[1], h[2], h[3], h[7], h[15:13]};
   endfunction : cf
   logic       wr_full;
   logic       hit0;
   pps_event_t ev0;
   assign wr_full = cyc_i && stb_i && we_i && !ack_o && ce_i &&
                    adr_i[ADDR_W-1:2] == '0 && sel_i == 4'hF;
   assign ev0 = ctr0_cfg_o.direction ? ev_tx_i : ev_rx_i;
   assign hit0 = ctr0_cfg_o.direction == DIR_RX && ev_rx_i.pkt_valid &&
                 ctr0_cfg_o.ev_type == PPS_EV_UC_REQ && !ev_rx_i.retried &&
                 !ev_rx_i.mcast && ev_rx_i.kind == PPS_PKT_REQUEST &&
                 ctr0_cfg_o.pri_en[ev_rx_i.prio];
   rsvd_zero_a: assert property (
      ack_o && !we_i |-> (dat_o & ~SEL_WMASK) == '0)
      else $error("reserved bits read nonzero");
   cfg0_write_a: assert property (
      wr_full |-> ##2 ctr0_cfg_o == cf($past(dat_i, 2), 1'h0))
      else $error("counter 0 setup differs from write");
   cfg1_write_a: assert property (
      wr_full |-> ##2 ctr1_cfg_o == cf($past(dat_i, 2), 1'h1))
      else $error("counter 1 setup differs from write");
   off0_quiet_a: assert property (
      (ce_i && ctr0_cfg_o.pri_en == 4'h0) ##1 ctr0_cfg_o.pri_en == 4'h0
      |-> !ctr0_inc_o) else $error("disabled counter 0 strobed");
   off1_quiet_a: assert property (
      (ce_i && ctr1_cfg_o.pri_en == 4'h0) ##1 ctr1_cfg_o.pri_en == 4'h0
      |-> !ctr1_inc_o) else $error("disabled counter 1 strobed");
   no_event_a: assert property (
      ce_i && !live(ev_rx_i) && !live(ev_tx_i) |=> !ctr0_inc_o && !ctr1_inc_o)
      else $error("strobe without a countable event");
   req0_count_a: assert property (
      (ce_i && hit0) ##1 $stable(ctr0_cfg_o) |-> ctr0_inc_o)
      else $error("unicast request not counted");
   dir0_select_a: assert property (
      (ce_i && !ev0.pkt_valid && !ev0.word_valid && !ev0.cs_valid)
      ##1 $stable(ctr0_cfg_o) |-> !ctr0_inc_o)
      else $error("counter 0 counted the other direction");
   cover property (ctr0_inc_o && ctr1_inc_o);
   cover property (wr_full);
   cover property (ack_o && !we_i);
endmodule : pps_select_asserts

bind pps_select pps_select_asserts #(.ADDR_W(ADDR_W)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
   .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ev_rx_i(ev_rx_i),
   .ev_tx_i(ev_tx_i), .ctr0_cfg_o(ctr0_cfg_o), .ctr1_cfg_o(ctr1_cfg_o),
   .ctr0_inc_o(ctr0_inc_o), .ctr1_inc_o(ctr1_inc_o));

// ### test/tb_pps_select.sv
/* Bench for the statistics select register bank.
   Drives Wishbone and event inputs; ce_i held high except in the final clock enable test. */
`timescale 1ns/1ps
module tb_pps_select
   import pps_pkg::*;
;
   typedef struct packed {
      logic [31:0] r;
      logic [11:0] e;
      logic        tx;
      logic [1:0]  x;
   } pps_row_t;
   localparam pps_row_t ROWS [0:27] = '{
      '{32'h0000_0001, 12'hB00, 1'h0, 2'h1},
      '{32'h0000_0002, 12'hB00, 1'h0, 2'h0},
      '{32'h0000_0002, 12'hA00, 1'h0, 2'h1},
      '{32'h0000_0004, 12'h900, 1'h0, 2'h1},
      '{32'h0000_0008, 12'h800, 1'h0, 2'h1},
      '{32'h0000_0000, 12'hB00, 1'h0, 2'h0},
      '{32'h000F_000F, 12'h800, 1'h0, 2'h3},
      '{32'h0001_0000, 12'hB00, 1'h0, 2'h2},
      '{32'h0002_0000, 12'hA00, 1'h0, 2'h2},
      '{32'h0008_0000, 12'h800, 1'h0, 2'h2},
      '{32'h0000_008F, 12'hB00, 1'h0, 2'h0},
      '{32'h0000_008F, 12'hB00, 1'h1, 2'h1},
      '{32'h008F_0000, 12'hB00, 1'h1, 2'h2},
      '{32'h000F_200F, 12'hB08, 1'h0, 2'h0},
      '{32'h0000_000F, 12'hB20, 1'h0, 2'h0},
      '{32'h0000_000F, 12'hB40, 1'h0, 2'h0},
      '{32'h0000_200F, 12'hB50, 1'h0, 2'h1},
      '{32'h0000_200F, 12'hB20, 1'h0, 2'h1},
      '{32'h0000_400F, 12'h006, 1'h0, 2'h1},
      '{32'h0000_400F, 12'h004, 1'h0, 2'h0},
      '{32'h0000_600F, 12'h004, 1'h0, 2'h1},
      '{32'h0000_800F, 12'h400, 1'h0, 2'h1},
      '{32'h0000_800F, 12'h800, 1'h0, 2'h0},
      '{32'h0000_A00F, 12'h880, 1'h0, 2'h1},
      '{32'h0000_C00F, 12'h005, 1'h0, 2'h1},
      '{32'h0000_E00F, 12'h480, 1'h0, 2'h1},
      '{32'h0000_E00F, 12'h400, 1'h0, 2'h0},
      '{32'hE00F_0000, 12'h480, 1'h0, 2'h2}
   };
   logic         clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0;
   logic         we_i = 1'h0, ce_i = 1'h1;
   logic [7:0]   adr_i = 8'h00;
   logic [3:0]   sel_i = 4'h0;
   logic [31:0]  dat_i = 32'h0, dat_o, rd;
   logic         ack_o, ctr0_inc_o, ctr1_inc_o;
   pps_event_t   ev_rx_i = '0, ev_tx_i = '0;
   pps_ctr_cfg_t ctr0_cfg_o, ctr1_cfg_o;
   int           err_total = 0, n_checks = 0;
   always #2.5 clk_i = ~clk_i;
   pps_select u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .ev_rx_i(ev_rx_i), .ev_tx_i(ev_tx_i), .ctr0_cfg_o(ctr0_cfg_o),
      .ctr1_cfg_o(ctr1_cfg_o), .ctr0_inc_o(ctr0_inc_o),
      .ctr1_inc_o(ctr1_inc_o));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_i);
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= s;
      do @(posedge clk_i); while (ack_o !== 1'h1);
      rd = dat_o;
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
   endtask : wb
   initial begin
      repeat (4000) @(posedge clk_i);
      err_total++;
      complete_run();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'h0;
      wb(1'h0, 8'h00, 32'h0, 4'hF);
      chk("reset value", 32'h0, rd);
      foreach (ROWS[i]) begin
         wb(1'h1, 8'h00, ROWS[i].r, 4'hF);
         @(posedge clk_i);
         if (ROWS[i].tx) ev_tx_i <= pps_event_t'(ROWS[i].e);
         else ev_rx_i <= pps_event_t'(ROWS[i].e);
         @(posedge clk_i);
         ev_rx_i <= '0;
         ev_tx_i <= '0;
         @(negedge clk_i);
         chk("strobes", 32'(ROWS[i].x), 32'({ctr1_inc_o, ctr0_inc_o}));
      end
      wb(1'h1, 8'h00, 32'hFFFF_FFFF, 4'hF);
      wb(1'h0, 8'h00, 32'h0, 4'hF);
      chk("all ones", 32'hE08F_E08F, rd);
      wb(1'h1, 8'h00, 32'h0, 4'h3);
      wb(1'h1, 8'h04, 32'hFFFF_FFFF, 4'hF);
      wb(1'h0, 8'h04, 32'h0, 4'hF);
      chk("unmapped", 32'h0, rd);
      wb(1'h0, 8'h00, 32'h0, 4'hF);
      chk("byte lanes", 32'hE08F_0000, rd);
      @(posedge clk_i);
      rst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      wb(1'h0, 8'h00, 32'h0, 4'hF);
      chk("second reset", 32'h0, rd);
      // A low clock enable holds the strobe; it fires once enabled again
      wb(1'h1, 8'h00, 32'h0000_000F, 4'hF);
      @(posedge clk_i);
      ce_i    <= 1'h0;
      ev_rx_i <= pps_event_t'(12'h800);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk("frozen strobe", 32'h0, 32'(ctr0_inc_o));
      @(posedge clk_i);
      ce_i <= 1'h1;
      @(posedge clk_i);
      ev_rx_i <= '0;
      @(negedge clk_i);
      chk("thawed strobe", 32'h1, 32'(ctr0_inc_o));
      complete_run();
   end
endmodule : tb_pps_select
